//--- card_resp_pkg.sv
// Constants shared by the response register bank and its CRC unit.
// Assumes a 32-bit APB master on pclk and a card link sampled on pclk.
// Overview of operation
// - CRC enable bit three gates the check
// - CRC covers R[47:1] or R[119:1]
// - Enabled check failures raise the error interrupt
// - Sub command bit only reported back
// - Type 00 none, 01 long, 10/11 short
// - Busy types wait for data line release
// - Four response words at 010h to 01Ch
// - Short responses store R[39:8] low word
// - Long responses store R[127:8] into bits 119:0
// - Auto stop response goes to top word
// - No-data command response stays in low word
// - Auto count response top word, errors reported
// - Partial updates keep other response bits
// - Serial abort responses at 018h and 01Ch
// - Buffer data port at offset 020h
// - Index enable gates index comparison
package card_resp_pkg;
  localparam int          ADDR_W        = 12;
  localparam int          STAT_W        = 4;
  // Register offsets
  localparam logic [11:0] OFF_CMD       = 12'h00C;
  localparam logic [11:0] OFF_RESP0     = 12'h010;
  localparam logic [11:0] OFF_RESP1     = 12'h014;
  localparam logic [11:0] OFF_RESP2     = 12'h018;
  localparam logic [11:0] OFF_RESP3     = 12'h01C;
  localparam logic [11:0] OFF_BUF       = 12'h020;
  localparam logic [11:0] OFF_STAT      = 12'h030;
  localparam logic [11:0] OFF_MASK      = 12'h034;
  localparam logic [11:0] OFF_RCTL      = 12'h038;
  localparam logic [11:0] OFF_STATE     = 12'h03C;
  // Command register fields
  localparam int          CMD_IDX_LSB   = 8;
  localparam int          CMD_IDXEN_BIT = 4;
  localparam int          CMD_CRCEN_BIT = 3;
  localparam int          CMD_SUB_BIT   = 2;
  localparam logic [15:0] CMD_WMASK     = 16'h3F1F;
  localparam logic [15:0] CMD_RESET     = 16'h0000;
  // Response type codes
  localparam logic [1:0]  RT_NONE       = 2'h0;
  localparam logic [1:0]  RT_LONG       = 2'h1;
  localparam logic [1:0]  RT_SHORT      = 2'h2;
  localparam logic [1:0]  RT_BUSY       = 2'h3;
  // Response control register: auto kind in [1:0], serial mode, card abort
  localparam logic [1:0]  AUTO_NONE     = 2'h0;
  localparam logic [1:0]  AUTO_STOP     = 2'h1;
  localparam logic [1:0]  AUTO_COUNT    = 2'h2;
  localparam int          RCTL_SER_BIT  = 2;
  localparam int          RCTL_CTA_BIT  = 3;
  localparam logic [3:0]  RCTL_RESET    = 4'h0;
  // Interrupt status bits
  localparam int          ST_DONE_BIT   = 0;
  localparam int          ST_CRC_BIT    = 1;
  localparam int          ST_IDX_BIT    = 2;
  localparam int          ST_AUTO_BIT   = 3;
  localparam logic [3:0]  MASK_RESET    = 4'h0;
  // Response framing, counted in link bits
  localparam logic [7:0]  LEN_SHORT     = 8'd48;
  localparam logic [7:0]  LEN_LONG      = 8'd136;
  localparam logic [7:0]  CRC_TOP_SHORT = 8'd47;
  localparam logic [7:0]  CRC_TOP_LONG  = 8'd119;
  localparam logic [6:0]  CRC7_POLY     = 7'h09;
  localparam logic [31:0] WORD_RESET    = 32'h0000_0000;
  typedef enum logic [4:0] {
    S_IDLE  = 5'b00001,
    S_WAIT  = 5'b00010,
    S_SHIFT = 5'b00100,
    S_CHECK = 5'b01000,
    S_BUSY  = 5'b10000
  } rx_state_t;
endpackage

//--- crc7_if.sv
// Carries serial bits from the response receiver to the CRC unit.
// Assumes both ends run on pclk.
`timescale 1ns/1ps
interface crc7_if;
  logic       clear;
  logic       valid;
  logic       din;
  logic [6:0] crc;
  modport calc (input clear, input valid, input din, output crc);
  modport user (output clear, output valid, output din, input crc);
endinterface

//--- crc7_unit.sv
// Serial CRC-7 accumulator; a zero remainder after the CRC bits means good.
// Assumes one bit per valid strobe, most significant bit first.
`timescale 1ns/1ps
module crc7_unit (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Bit stream
  crc7_if.calc      bus
);
  import card_resp_pkg::*;
  logic fb;
  assign fb = bus.din ^ bus.crc[6];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus.crc <= 7'h00;
    end else if (bus.clear) begin
      bus.crc <= 7'h00;
    end else if (bus.valid) begin
      bus.crc <= {bus.crc[5:0], 1'b0} ^ (fb ? CRC7_POLY : 7'h00);
    end
  end
endmodule

//--- card_cmd_response_regs.sv
// Response handling for a memory-card host: command fields, response
// receive and check, 128-bit response store, buffer data port.
// Assumes an APB master on pclk; card clock and lines arrive asynchronously.
`timescale 1ns/1ps
module card_cmd_response_regs (
  // Clock and reset
  input  wire logic                             pclk,
  input  wire logic                             presetn,
  // APB slave
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [card_resp_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                      pwdata,
  output logic      [31:0]                      prdata,
  output logic                                  pready,
  output logic                                  pslverr,
  // Card link
  input  wire logic                             card_clk,
  input  wire logic                             card_cmd,
  input  wire logic                             card_dat0,
  // Interrupt
  output logic                                  irq
);
  import card_resp_pkg::*;

  logic [2:0]        clk_sync_reg;
  logic [1:0]        cmd_sync_reg;
  logic [1:0]        dat0_sync_reg;
  logic              link_rise;
  logic              cmd_s;
  logic              dat0_s;
  logic              acc;
  logic              wr;
  logic              rd;
  logic              hit;
  logic [31:0]       rd_mux;
  logic [15:0]       cmd_reg;
  logic [3:0]        rctl_reg;
  logic [3:0]        mask_reg;
  logic [31:0]       buf_reg;
  logic [STAT_W-1:0] stat_reg;
  logic [STAT_W-1:0] snap_reg;
  logic [STAT_W-1:0] stat_set;
  logic [STAT_W-1:0] stat_clr;
  logic [127:0]      resp_reg;
  rx_state_t         st_reg;
  logic [7:0]        cnt_reg;
  logic [135:0]      sr_reg;
  logic              long_reg;
  logic              issue;
  logic              issue_none;
  logic [7:0]        crc_top;
  logic              crc_err;
  logic              idx_err;
  logic              busy_end;
  logic [1:0]        rtype;
  logic [1:0]        auto_kind;

  crc7_if crc_bus ();

  crc7_unit u_crc (
    .pclk    (pclk),
    .presetn (presetn),
    .bus     (crc_bus)
  );

  // Two-stage synchronisers; stage two onward feeds logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_sync_reg  <= 3'h0;
      cmd_sync_reg  <= 2'h3;
      dat0_sync_reg <= 2'h3;
    end else begin
      clk_sync_reg  <= {clk_sync_reg[1:0], card_clk};
      cmd_sync_reg  <= {cmd_sync_reg[0], card_cmd};
      dat0_sync_reg <= {dat0_sync_reg[0], card_dat0};
    end
  end

  assign link_rise = clk_sync_reg[1] & ~clk_sync_reg[2];
  assign cmd_s     = cmd_sync_reg[1];
  assign dat0_s    = dat0_sync_reg[1];

  // APB: one wait state, answer registered
  assign acc = psel & penable;
  assign wr  = acc & pready & pwrite;
  assign rd  = acc & pready & ~pwrite;

  always_comb begin
    hit    = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      OFF_CMD:   rd_mux = {16'h0000, cmd_reg};
      OFF_RESP0: rd_mux = resp_reg[31:0];
      OFF_RESP1: rd_mux = resp_reg[63:32];
      OFF_RESP2: rd_mux = resp_reg[95:64];
      OFF_RESP3: rd_mux = resp_reg[127:96];
      OFF_BUF:   rd_mux = buf_reg;
      OFF_STAT:  rd_mux = {28'h000_0000, stat_reg};
      OFF_MASK:  rd_mux = {28'h000_0000, mask_reg};
      OFF_RCTL:  rd_mux = {28'h000_0000, rctl_reg};
      OFF_STATE: rd_mux = {29'h000_0000, st_reg == S_BUSY, st_reg != S_IDLE,
                           cmd_reg[CMD_SUB_BIT]};
      default:   hit    = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
      snap_reg <= '0;
    end else begin
      pready  <= acc & ~pready;
      pslverr <= acc & ~pready & ~hit;
      if (acc & ~pready) begin
        prdata   <= rd_mux;
        snap_reg <= (paddr == OFF_STAT) ? stat_reg : '0;
      end
    end
  end

  // Software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_reg  <= CMD_RESET;
      rctl_reg <= RCTL_RESET;
      mask_reg <= MASK_RESET;
      buf_reg  <= WORD_RESET;
    end else if (wr) begin
      case (paddr)
        OFF_CMD:  cmd_reg  <= pwdata[15:0] & CMD_WMASK;
        OFF_RCTL: rctl_reg <= pwdata[3:0];
        OFF_MASK: mask_reg <= pwdata[3:0];
        OFF_BUF:  buf_reg  <= pwdata;
        default:  cmd_reg  <= cmd_reg;
      endcase
    end
  end

  assign rtype      = cmd_reg[1:0];
  assign auto_kind  = rctl_reg[1:0];
  assign issue      = wr && paddr == OFF_CMD && st_reg == S_IDLE
                      && pwdata[1:0] != RT_NONE;
  assign issue_none = wr && paddr == OFF_CMD && st_reg == S_IDLE
                      && pwdata[1:0] == RT_NONE;
  assign crc_top    = long_reg ? CRC_TOP_LONG : CRC_TOP_SHORT;

  // CRC feed: every bit whose index lies in 1..top
  assign crc_bus.clear = issue;
  assign crc_bus.din   = cmd_s;
  assign crc_bus.valid = link_rise && (
                         (st_reg == S_WAIT && !cmd_s && !long_reg) ||
                         (st_reg == S_SHIFT && cnt_reg != 8'd0 && cnt_reg <= crc_top));

  // Response receiver
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg   <= S_IDLE;
      cnt_reg  <= 8'd0;
      sr_reg   <= '0;
      long_reg <= 1'b0;
    end else begin
      case (st_reg)
        S_IDLE: begin
          if (issue) begin
            st_reg   <= S_WAIT;
            long_reg <= pwdata[1:0] == RT_LONG;
          end
        end
        S_WAIT: begin
          if (link_rise && !cmd_s) begin
            st_reg  <= S_SHIFT;
            cnt_reg <= (long_reg ? LEN_LONG : LEN_SHORT) - 8'd2;
            sr_reg  <= '0;
          end
        end
        S_SHIFT: begin
          if (link_rise) begin
            sr_reg <= {sr_reg[134:0], cmd_s};
            if (cnt_reg == 8'd0) begin
              st_reg <= S_CHECK;
            end else begin
              cnt_reg <= cnt_reg - 8'd1;
            end
          end
        end
        S_CHECK: begin
          st_reg <= (rtype == RT_BUSY) ? S_BUSY : S_IDLE;
        end
        S_BUSY: begin
          if (link_rise && dat0_s) begin
            st_reg <= S_IDLE;
          end
        end
        default: st_reg <= S_IDLE;
      endcase
    end
  end

  // Checks, each only when its enable is set
  assign crc_err  = st_reg == S_CHECK && cmd_reg[CMD_CRCEN_BIT]
                    && crc_bus.crc != 7'h00;
  assign idx_err  = st_reg == S_CHECK && cmd_reg[CMD_IDXEN_BIT]
                    && !long_reg
                    && sr_reg[45:40] != cmd_reg[CMD_IDX_LSB +: 6];
  assign busy_end = st_reg == S_BUSY && link_rise && dat0_s;

  always_comb begin
    stat_set               = '0;
    stat_set[ST_CRC_BIT]   = crc_err;
    stat_set[ST_IDX_BIT]   = idx_err;
    stat_set[ST_AUTO_BIT]  = (crc_err | idx_err) && !long_reg
                             && auto_kind == AUTO_COUNT;
    stat_set[ST_DONE_BIT]  = issue_none | busy_end
                             | (st_reg == S_CHECK && rtype != RT_BUSY);
    stat_clr               = rd ? snap_reg : '0;
  end

  // Sticky status: a new event wins over a read clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_reg <= '0;
      irq      <= 1'b0;
    end else begin
      stat_reg <= (stat_reg & ~stat_clr) | stat_set;
      irq      <= |(stat_reg & mask_reg);
    end
  end

  // Response store; untouched bits keep their value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resp_reg <= '0;
    end else if (st_reg == S_CHECK) begin
      if (!long_reg) begin
        if (auto_kind != AUTO_NONE) begin
          resp_reg[127:96] <= sr_reg[39:8];
        end else begin
          resp_reg[31:0]   <= sr_reg[39:8];
        end
      end else if (rctl_reg[RCTL_SER_BIT] && rctl_reg[RCTL_CTA_BIT]) begin
        resp_reg[127:64] <= sr_reg[71:8];
      end else begin
        resp_reg[119:0]  <= sr_reg[127:8];
      end
    end
  end

  sequence resp_short_normal;
    st_reg == S_CHECK && !long_reg && auto_kind == AUTO_NONE;
  endsequence

  sequence resp_short_auto;
    st_reg == S_CHECK && !long_reg && auto_kind != AUTO_NONE;
  endsequence

  sequence resp_long_plain;
    st_reg == S_CHECK && long_reg && !rctl_reg[RCTL_SER_BIT];
  endsequence

  sequence resp_long_serial;
    st_reg == S_CHECK && long_reg && rctl_reg[RCTL_SER_BIT] && rctl_reg[RCTL_CTA_BIT];
  endsequence

  sequence busy_release;
    st_reg == S_BUSY && link_rise && dat0_s;
  endsequence

  chk_crc_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_reg == S_CHECK && cmd_reg[CMD_CRCEN_BIT] && crc_bus.crc != 7'h00
    |=> stat_reg[ST_CRC_BIT])
    else $error("CRC mismatch not flagged");

  chk_crc_off: assert property (
    @(posedge pclk) disable iff (!presetn)
    !stat_reg[ST_CRC_BIT] && !cmd_reg[CMD_CRCEN_BIT] && st_reg == S_CHECK
    |=> !stat_reg[ST_CRC_BIT])
    else $error("CRC flagged while check disabled");

  chk_index_off: assert property (
    @(posedge pclk) disable iff (!presetn)
    !stat_reg[ST_IDX_BIT] && !cmd_reg[CMD_IDXEN_BIT] && st_reg == S_CHECK
    |=> !stat_reg[ST_IDX_BIT])
    else $error("Index flagged while check disabled");

  chk_type_length: assert property (
    @(posedge pclk) disable iff (!presetn)
    issue |=> st_reg == S_WAIT && long_reg == ($past(pwdata[1:0]) == RT_LONG))
    else $error("Response length does not follow type");

  chk_busy_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_reg == S_BUSY && !dat0_s |=> st_reg == S_BUSY)
    else $error("Busy wait left while line low");

  chk_store_low: assert property (
    @(posedge pclk) disable iff (!presetn)
    resp_short_normal |=> resp_reg[31:0] == $past(sr_reg[39:8])
                          && $stable(resp_reg[127:96]))
    else $error("Short response not in low word");

  chk_auto_high: assert property (
    @(posedge pclk) disable iff (!presetn)
    resp_short_auto |=> resp_reg[127:96] == $past(sr_reg[39:8])
                        && $stable(resp_reg[31:0]))
    else $error("Auto response misplaced or low word disturbed");

  chk_long_keep: assert property (
    @(posedge pclk) disable iff (!presetn)
    resp_long_plain |=> resp_reg[119:0] == $past(sr_reg[127:8])
                        && $stable(resp_reg[127:120]))
    else $error("Long response store wrong");

  chk_done_after: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_reg == S_CHECK && rtype != RT_BUSY
    |=> stat_reg[ST_DONE_BIT] ##1 irq == |(mask_reg & $past(stat_reg)))
    else $error("Completion not signalled after store");

  chk_apb_answer: assert property (
    @(posedge pclk) disable iff (!presetn)
    acc && !pready |=> pready ##1 !pready)
    else $error("APB answer not one wait state");

  chk_index_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_reg == S_CHECK && cmd_reg[CMD_IDXEN_BIT] && !long_reg
    && sr_reg[45:40] != cmd_reg[CMD_IDX_LSB +: 6] |=> stat_reg[ST_IDX_BIT])
    else $error("Index mismatch not flagged");

  chk_serial_abort: assert property (
    @(posedge pclk) disable iff (!presetn)
    resp_long_serial |=> resp_reg[127:64] == $past(sr_reg[71:8])
                         && $stable(resp_reg[63:0]))
    else $error("Card abort response misplaced");

  chk_busy_release: assert property (
    @(posedge pclk) disable iff (!presetn)
    busy_release |=> st_reg == S_IDLE && stat_reg[ST_DONE_BIT])
    else $error("Busy end not completed");

  chk_auto_error: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_reg == S_CHECK && !long_reg && auto_kind == AUTO_COUNT
    && cmd_reg[CMD_CRCEN_BIT] && crc_bus.crc != 7'h00 |=> stat_reg[ST_AUTO_BIT])
    else $error("Auto count error not reported");

  chk_no_resp_done: assert property (
    @(posedge pclk) disable iff (!presetn)
    issue_none |=> st_reg == S_IDLE && stat_reg[ST_DONE_BIT])
    else $error("No-response command not completed");
endmodule

//--- card_model.sv
// Card-side model: sends responses on the command line, busy on data line 0.
// Assumes the host samples both lines on the card clock's rising edge.
`timescale 1ns/1ps
module card_model (
  // Card link
  output logic card_clk,
  output logic card_cmd,
  output logic card_dat0
);
  initial begin
    card_clk  = 1'b0;
    card_cmd  = 1'b1;
    card_dat0 = 1'b1;
  end
  // One link bit: data set while low, then rise and fall
  task automatic tick();
    #80 card_clk = 1'b1;
    #80 card_clk = 1'b0;
  endtask
  // Clock stands still between frames; both lines rest at the pull-up level
  task automatic send(input logic [135:0] v, input int len, input int busy);
    // Step off the host clock edges so no link change meets a sampling edge
    #5;
    repeat (4) tick();
    for (int i = len - 1; i >= 0; i--) begin
      card_cmd = v[i];
      tick();
    end
    card_cmd = 1'b1;
    if (busy > 0) begin
      card_dat0 = 1'b0;
      repeat (busy) tick();
    end
    card_dat0 = 1'b1;
    // Returns at the rise that shows the line released
    #80 card_clk = 1'b1;
    card_clk <= #80 1'b0;
  endtask
endmodule

//--- tb.sv
// Self-checking bench for the response register bank.
// Assumes the card model drives the link and APB answers after one wait state.
`timescale 1ns/1ps
module tb;
  import card_resp_pkg::*;
  typedef struct packed {
    logic [31:0] d;
    logic [31:0] m;
    logic        e;
  } exp_t;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic         card_clk, card_cmd, card_dat0;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, a1, a2, w3;
  logic [135:0] va, vb;
  logic [127:0] p;
  logic [11:0]  regs [10] = '{OFF_RESP0, OFF_RESP1, OFF_RESP2, OFF_RESP3, OFF_BUF,
                            OFF_CMD, OFF_STAT, OFF_MASK, OFF_RCTL, OFF_STATE};
  exp_t         q[$];
  int           error_cnt = 0;
  int           checks_done = 0;
  int           seed = 32'h69f9;

  card_cmd_response_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .card_clk(card_clk),
    .card_cmd(card_cmd), .card_dat0(card_dat0), .irq(irq));
  card_model u_card (.card_clk(card_clk), .card_cmd(card_cmd), .card_dat0(card_dat0));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  function automatic logic [6:0] crc7(input logic [135:0] v, input int top);
    logic [6:0] c;
    logic       fb;
    c = 7'h00;
    for (int i = top; i >= 8; i--) begin
      fb = v[i] ^ c[6];
      c = {c[5:0], 1'b0} ^ (fb ? CRC7_POLY : 7'h00);
    end
    return c;
  endfunction
  function automatic logic [135:0] shortr(input logic [5:0] idx, input logic [31:0] arg);
    logic [135:0] v;
    v = {88'h0, 2'b00, idx, arg, 8'h01};
    v[7:1] = crc7(v, 47);
    return v;
  endfunction
  function automatic logic [135:0] longr(input logic [119:0] pl);
    logic [135:0] v;
    v = {2'b00, 6'h3F, pl, 8'h01};
    v[7:1] = crc7(v, 119);
    return v;
  endfunction
  function automatic logic [31:0] cw(input logic [5:0] idx, input logic [2:0] en,
                                     input logic [1:0] t);
    return {18'h0, idx, 3'b000, en, t};
  endfunction
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input exp_t x);
    int n;
    n = 0;
    q.push_back(x);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) chk(32'h0, 32'h1);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, '{32'h0, 32'h0, 1'b0});
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic e = 1'b0);
    apb(1'b0, a, 32'h0, '{x, 32'hFFFF_FFFF, e});
  endtask
  // Issue one command, let the card answer, then collect and clear status
  task automatic run(input logic [31:0] c, input logic [3:0] rc, input logic [135:0] v,
                     input int len, input int busy, input logic [3:0] st);
    int n;
    n = 0;
    wr(OFF_RCTL, {28'h0, rc});
    wr(OFF_CMD, c);
    u_card.send(v, len, busy);
    if (busy > 0) chk({31'h0, irq}, 32'h0);
    while (irq !== 1'b1 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, irq}, 32'h1);
    rd(OFF_STAT, {28'h0, st});
    rd(OFF_STAT, 32'h0);
  endtask

  always @(posedge pclk) begin : mon
    exp_t x;
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      x = q.pop_front();
      chk(prdata & x.m, x.d & x.m);
      chk({31'h0, pslverr}, {31'h0, x.e});
    end
  end
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    repeat (60000) @(posedge pclk);
    error_cnt++;
    finish_test();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    foreach (regs[i]) rd(regs[i], 32'h0);
    rd(12'h040, 32'h0, 1'b1);
    a1 = $random(seed);
    wr(OFF_BUF, a1);
    rd(OFF_BUF, a1);
    wr(OFF_RESP0, 32'hFFFF_FFFF);
    rd(OFF_RESP0, 32'h0);
    // No-response command with the sub flag, interrupt masked then unmasked
    wr(OFF_CMD, cw(6'd5, 3'b001, RT_NONE));
    rd(OFF_CMD, cw(6'd5, 3'b001, RT_NONE));
    rd(OFF_STATE, 32'h1);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    wr(OFF_MASK, 32'h1);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    rd(OFF_STAT, 32'h1);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    run(cw(6'd12, 3'b110, RT_SHORT), {2'b0, AUTO_STOP}, shortr(6'd12, a1), 48, 0, 4'h1);
    rd(OFF_RESP3, a1);
    rd(OFF_RESP0, 32'h0);
    p = {$random(seed), $random(seed), $random(seed), $random(seed)};
    vb = longr(p[119:0]);
    run(cw(6'd2, 3'b010, RT_LONG), 4'h0, vb, 136, 0, 4'h1);
    w3 = {a1[31:24], vb[127:104]};
    rd(OFF_RESP0, vb[39:8]);
    rd(OFF_RESP1, vb[71:40]);
    rd(OFF_RESP2, vb[103:72]);
    rd(OFF_RESP3, w3);
    run(cw(6'd2, 3'b010, RT_LONG), 4'h0, vb ^ 136'h2, 136, 0, 4'h3);
    a2 = $random(seed);
    va = shortr(6'd17, a2);
    run(cw(6'd17, 3'b110, RT_SHORT), 4'h0, va, 48, 0, 4'h1);
    rd(OFF_RESP0, a2);
    rd(OFF_RESP3, w3);
    run(cw(6'd17, 3'b110, RT_SHORT), 4'h0, va ^ 136'h2, 48, 0, 4'h3);
    run(cw(6'd17, 3'b000, RT_SHORT), 4'h0, va | 136'hFE, 48, 0, 4'h1);
    run(cw(6'd16, 3'b110, RT_SHORT), 4'h0, va, 48, 0, 4'h5);
    run(cw(6'd16, 3'b010, RT_SHORT), 4'h0, va, 48, 0, 4'h1);
    a2 = $random(seed);
    run(cw(6'd23, 3'b110, RT_SHORT), {2'b0, AUTO_COUNT}, shortr(6'd23, a2), 48, 0, 4'h1);
    rd(OFF_RESP3, a2);
    run(cw(6'd23, 3'b110, RT_SHORT), {2'b0, AUTO_COUNT}, shortr(6'd23, a2) ^ 136'h2, 48,
        0, 4'hB);
    a1 = $random(seed);
    run(cw(6'd7, 3'b110, RT_BUSY), 4'h0, shortr(6'd7, a1), 48, 10, 4'h1);
    rd(OFF_RESP0, a1);
    // Serial mode with card-transaction abort
    p = {$random(seed), $random(seed), $random(seed), $random(seed)};
    vb = longr(p[119:0]);
    run(cw(6'd2, 3'b010, RT_LONG), 4'hC, vb, 136, 0, 4'h1);
    rd(OFF_RESP2, vb[39:8]);
    rd(OFF_RESP3, vb[71:40]);
    rd(OFF_RESP0, a1);
    // Let the monitor take the last answer before the verdict
    repeat (2) @(posedge pclk);
    finish_test();
  end
endmodule
